// [src/burst_read_ctrl.v]
// Burst read control: sample count register, sample FIFO and byte sequencer
`include "burst_read_regs.vh"
`default_nettype none

module burst_read_ctrl #(
  parameter DEPTH = `FIFO_DEPTH_DEFAULT,
  parameter AW    = `FIFO_ADDR_DEFAULT
) (
  input  wire                     clk,
  input  wire                     reset,
  input  wire [7:0]               reg_addr,
  input  wire                     reg_wr,
  input  wire                     reg_rd,
  input  wire [7:0]               reg_wdata,
  output reg  [7:0]               reg_rdata,
  output reg                      reg_rvalid,
  input  wire                     burst_en,
  input  wire [1:0]               status_len,
  input  wire [7:0]               status_a,
  input  wire [7:0]               status_b,
  input  wire [`SAMPLE_WIDTH-1:0] smp_data,
  input  wire                     smp_valid,
  output reg                      smp_ready,
  input  wire                     txn_start,
  input  wire                     txn_end,
  input  wire                     byte_req,
  output reg  [7:0]               byte_data,
  output reg                      byte_valid,
  output reg                      burst_done,
  output reg                      underrun,
  output reg                      busy
);

  localparam ST_IDLE   = 2'b00;
  localparam ST_ACTIVE = 2'b01;
  localparam ST_DONE   = 2'b10;

  reg  [7:0] sample_count_r;
  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg        limit_r;
  reg  [7:0] target_r;
  reg  [7:0] sent_r;
  reg  [3:0] bytes_per_sample_r;
  reg  [3:0] byte_idx_r;
  reg  [7:0] byte_nxt;
  reg        pop_nxt;
  reg        done_nxt;
  reg        under_nxt;

  wire [`SAMPLE_WIDTH-1:0] head_data;
  wire                     head_valid;
  wire                     fifo_in_ready;
  wire [AW:0]              fifo_level;
  wire [1:0]               status_len_clip;
  wire                     last_byte;
  wire                     reg_hit;
  wire                     smp_take;

  assign reg_hit         = (reg_addr == `SAMPLE_COUNT_ADDR);
  // Push only on a real handshake, or the FIFO would store a sample the producer still holds
  assign smp_take        = smp_valid & smp_ready;
  assign status_len_clip = (status_len > `STATUS_LEN_MAX) ? `STATUS_LEN_MAX : status_len;
  assign last_byte       = (byte_idx_r == (bytes_per_sample_r - 4'h1));

  // Samples wait here until the host drains them; a full FIFO stalls the producer
  sample_fifo #(
    .WIDTH (`SAMPLE_WIDTH),
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_data   (smp_data),
    .in_valid  (smp_take),
    .in_ready  (fifo_in_ready),
    .out_data  (head_data),
    .out_valid (head_valid),
    .out_ready (pop_nxt),
    .level     (fifo_level)
  );

  // Producer ready is registered so it comes straight from a flop; one sample of slack is kept
  always @(posedge clk) begin
    if (reset) begin
      smp_ready <= 1'b0;
    end else begin
      smp_ready <= fifo_in_ready && (fifo_level < (DEPTH[AW:0] - {{AW{1'b0}}, 1'b1}));
    end
  end

  // Count register write and one-cycle read answer; other offsets read zero
  always @(posedge clk) begin
    if (reset) begin
      sample_count_r <= `SAMPLE_COUNT_RESET;
      reg_rdata      <= 8'h00;
      reg_rvalid     <= 1'b0;
    end else begin
      if (reg_wr && reg_hit) begin
        sample_count_r <= reg_wdata;
      end
      reg_rvalid <= reg_rd;
      reg_rdata  <= (reg_rd && reg_hit) ? sample_count_r : 8'h00;
    end
  end

  // Byte selection, pop and termination decisions for the next host byte
  always @* begin
    state_nxt = state_r;
    byte_nxt  = 8'h00;
    pop_nxt   = 1'b0;
    done_nxt  = 1'b0;
    under_nxt = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (txn_start) begin
          // A zero count in burst mode leaves nothing to send
          state_nxt = (burst_en && (sample_count_r == 8'h00)) ? ST_DONE : ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (txn_end) begin
          state_nxt = ST_IDLE;
        end else if (byte_req) begin
          if (byte_idx_r < `AXIS_BYTES) begin
            byte_nxt  = head_valid ? head_data[{byte_idx_r[2:0], 3'b000} +: 8] : 8'h00;
            under_nxt = ~head_valid;
          end else if (byte_idx_r == `STATUS_A_INDEX) begin
            byte_nxt = status_a;
          end else begin
            byte_nxt = status_b;
          end
          if (last_byte) begin
            // A sample is consumed only when its final byte goes out
            pop_nxt = head_valid;
            if (limit_r && (sent_r == (target_r - 8'h01))) begin
              state_nxt = ST_DONE;
              done_nxt  = 1'b1;
            end
          end
        end
      end
      ST_DONE: begin
        // Bytes beyond the burst read zero and touch no FIFO data
        if (txn_end) begin
          state_nxt = ST_IDLE;
        end else if (byte_req) begin
          done_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Transaction state, counters and registered byte stream outputs
  always @(posedge clk) begin
    if (reset) begin
      state_r            <= ST_IDLE;
      limit_r            <= 1'b0;
      target_r           <= 8'h00;
      sent_r             <= 8'h00;
      bytes_per_sample_r <= `AXIS_BYTES;
      byte_idx_r         <= 4'h0;
      byte_data          <= 8'h00;
      byte_valid         <= 1'b0;
      burst_done         <= 1'b0;
      underrun           <= 1'b0;
      busy               <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      byte_valid <= byte_req && (state_r != ST_IDLE) && !txn_end;
      byte_data  <= byte_nxt;
      underrun   <= under_nxt;
      busy       <= (state_nxt != ST_IDLE);
      if (state_r == ST_IDLE && txn_start) begin
        // Mode, count and sample length are frozen for the whole transaction
        limit_r            <= burst_en;
        target_r           <= sample_count_r;
        sent_r             <= 8'h00;
        byte_idx_r         <= 4'h0;
        bytes_per_sample_r <= burst_en ? (`AXIS_BYTES + {2'b00, status_len_clip}) : `AXIS_BYTES;
        burst_done         <= burst_en && (sample_count_r == 8'h00);
      end else begin
        if (done_nxt) begin
          burst_done <= 1'b1;
        end else if (state_nxt == ST_IDLE) begin
          burst_done <= 1'b0;
        end
        if (state_r == ST_ACTIVE && byte_req && !txn_end) begin
          if (last_byte) begin
            byte_idx_r <= 4'h0;
            sent_r     <= sent_r + 8'h01;
          end else begin
            byte_idx_r <= byte_idx_r + 4'h1;
          end
        end
      end
    end
  end

endmodule // burst_read_ctrl

`default_nettype wire

// [shared/burst_read_regs.vh]
// Register map, reset values and sample layout constants for the burst read block
`ifndef BURST_READ_REGS_VH
`define BURST_READ_REGS_VH

`define SAMPLE_COUNT_ADDR   8'h4b
`define SAMPLE_COUNT_RESET  8'h06
`define AXIS_BYTES          4'h6
`define STATUS_A_INDEX      4'h6
`define STATUS_B_INDEX      4'h7
`define STATUS_LEN_MAX      2'h2
`define SAMPLE_WIDTH        48
`define FIFO_DEPTH_DEFAULT  16
`define FIFO_ADDR_DEFAULT   4

`endif

// [src/sample_fifo.v]
// Synchronous FIFO with valid/ready on both sides, holding whole samples
`default_nettype none

module sample_fifo #(
  parameter WIDTH = 48,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire             clk,
  input  wire             reset,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output wire [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready,
  output wire [AW:0]      level
);

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;

  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  // Full and empty come from the occupancy count, so both flags are exact
  assign in_ready  = (count_r != DEPTH[AW:0]);
  assign out_valid = (count_r != {(AW+1){1'b0}});
  assign out_data  = mem_r[rd_ptr_r];
  assign level     = count_r;

  // Storage has no reset; only pointers and count need a defined value
  always @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointer and occupancy update; depth is a power of two so pointers wrap freely
  always @(posedge clk) begin
    if (reset) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end

endmodule // sample_fifo

`default_nettype wire

// [tb/burst_read_sva.sv]
// Assertion checker for the burst read control ports
`default_nettype none
module burst_read_sva (
  input wire logic       clk,
  input wire logic       reset,
  input wire logic [7:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       txn_end,
  input wire logic       byte_req,
  input wire logic [7:0] byte_data,
  input wire logic       byte_valid,
  input wire logic       burst_done,
  input wire logic       underrun,
  input wire logic       busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // A byte request taken while a transaction is open
  sequence s_ask;
    byte_req && busy && !txn_end;
  endsequence
  sequence s_give;
    byte_valid;
  endsequence
  a_byte_answer: assert property (s_ask |=> s_give)
    else $error("byte request not answered");
  a_idle_silent: assert property (byte_req && !busy |=> !byte_valid)
    else $error("byte answered while idle");
  // Once the count is reached, further bytes carry no FIFO data
  a_done_zero: assert property ($past(burst_done) && byte_valid |-> byte_data == 8'h00)
    else $error("byte after burst end not zero");
  a_done_holds: assert property (burst_done && !txn_end |=> burst_done)
    else $error("burst done dropped early");
  a_end_idle: assert property (txn_end && busy |=> !busy && !burst_done)
    else $error("transaction did not close");
  a_reg_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("register read not answered");
  a_reg_other_zero: assert property (reg_rvalid && $past(reg_addr) != 8'h4b |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // An empty-FIFO axis byte is flagged together with its zero answer
  a_under_pulse: assert property (underrun |-> byte_valid && byte_data == 8'h00)
    else $error("underrun without zero byte");
endmodule // burst_read_sva
bind burst_read_ctrl burst_read_sva i_sva (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .txn_end(txn_end), .byte_req(byte_req),
  .byte_data(byte_data), .byte_valid(byte_valid), .burst_done(burst_done), .underrun(underrun), .busy(busy));
`default_nettype wire

// [tb/sample_source.sv]
// Sample producer model feeding numbered samples into the block
`default_nettype none
module sample_source (
  input  wire logic        clk,
  input  wire logic        reset,
  output var  logic [47:0] smp_data,
  output var  logic        smp_valid,
  input  wire logic        smp_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] n_r;
  // Byte k of sample n is n*8+k, so order and framing show in the stream
  always_comb for (int k = 0; k < 6; k++) smp_data[8*k +: 8] = 8'(n_r * 8 + k);
  // Each sample is held until it is accepted
  always @(posedge clk) begin
    if (reset) begin
      n_r <= 8'h00;
      smp_valid <= 1'b0;
    end else begin
      smp_valid <= 1'b1;
      if (smp_valid && smp_ready) n_r <= n_r + 8'h01;
    end
  end
endmodule // sample_source
`default_nettype wire

// [tb/fifo_burst_read_count_test.sv]
// Self-checking bench for the burst read control block
`default_nettype none
module fifo_burst_read_count_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, burst_en = 0, txn_start = 0, txn_end = 0, byte_req = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, status_a = 8'h3c, status_b = 8'hc3, reg_rdata, byte_data;
  logic [1:0] status_len = 0;
  logic [47:0] smp_data;
  logic smp_valid, smp_ready, reg_rvalid, byte_valid, burst_done, underrun, busy;
  int fail_count = 0, comparisons = 0, next_s = 0;
  initial forever #2.5 clk = ~clk;
  burst_read_ctrl i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .burst_en(burst_en),
    .status_len(status_len), .status_a(status_a), .status_b(status_b), .smp_data(smp_data),
    .smp_valid(smp_valid), .smp_ready(smp_ready), .txn_start(txn_start), .txn_end(txn_end),
    .byte_req(byte_req), .byte_data(byte_data), .byte_valid(byte_valid), .burst_done(burst_done),
    .underrun(underrun), .busy(busy));
  sample_source i_src (.clk(clk), .reset(reset), .smp_data(smp_data), .smp_valid(smp_valid),
    .smp_ready(smp_ready));
  task give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string what, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", what, e, s);
      fail_count++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk); reg_addr = a; reg_wdata = d; reg_wr = 1;
    @(negedge clk); reg_wr = 0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk); reg_addr = a; reg_rd = 1;
    @(negedge clk); reg_rd = 0;
    chk("reg_rvalid", 8'h01, {7'h0, reg_rvalid});
    chk("reg_rdata", e, reg_rdata);
  endtask
  // One byte request; answer and flags are looked at one cycle later
  task get(input logic [7:0] e, input logic d);
    @(negedge clk); byte_req = 1;
    @(negedge clk); byte_req = 0;
    chk("byte_data", e, byte_data);
    chk("byte_flags", {5'h0, 1'b1, d, 1'b0}, {5'h0, byte_valid, burst_done, underrun});
  endtask
  // Host reads ns whole samples in one transaction, then nx bytes past the end
  task burst(input logic en, input logic [1:0] sl, input int ns, input int nx);
    int len;
    len = en ? 6 + (sl > 2 ? 2 : sl) : 6;
    burst_en = en; status_len = sl;
    @(negedge clk); txn_start = 1;
    @(negedge clk); txn_start = 0;
    for (int j = 0; j < ns; j++) begin
      for (int k = 0; k < len; k++)
        get(k < 6 ? 8'(next_s * 8 + k) : (k == 6 ? status_a : status_b), en && j == ns - 1 && k == len - 1);
      next_s++;
    end
    repeat (nx) get(8'h00, 1'b1);
    @(negedge clk); txn_end = 1;
    @(negedge clk); txn_end = 0;
    chk("busy", 8'h00, {7'h0, busy});
  endtask
  initial begin
    repeat (12) @(negedge clk);
    reset = 0;
    repeat (20) @(negedge clk);
    // By now the producer has filled the FIFO and must be stalled
    chk("smp_ready", 8'h00, {7'h0, smp_ready});
    rd(8'h4b, 8'h06);
    wr(8'h4b, 8'h5a);
    rd(8'h4b, 8'h5a);
    wr(8'h4a, 8'hff);
    rd(8'h4a, 8'h00);
    rd(8'h4b, 8'h5a);
    $display("test registers done");
    // Every status length, including the clipped code 3
    for (int s = 0; s < 4; s++) begin
      wr(8'h4b, 8'h02);
      burst(1, s[1:0], 2, 2);
      $display("test burst status_len %0d done", s);
    end
    wr(8'h4b, 8'h01);
    burst(0, 2'h2, 3, 0);
    $display("test non-burst done");
    wr(8'h4b, 8'h00);
    burst(1, 2'h0, 0, 2);
    $display("test zero count done");
    give_verdict;
  end
  // Guard against a hang
  initial begin
    #100us;
    fail_count++;
    give_verdict;
  end
endmodule // fifo_burst_read_count_test
`default_nettype wire
